// ---- sfr_pkg.sv ----
// shared constants and types for the special-function register bank
package sfr_pkg;
    localparam int DATA_W = 8;
    localparam int FILE_AW = 5;
    localparam int PC_W = 11;
    localparam int STACK_DEPTH = 8;
    localparam int MODE_W = 4;
    localparam int PAGE_SHIFT = 9;
    localparam int RAM_DEPTH = 24;
    localparam int PIN_W = 24;
    // file addresses
    localparam logic [4:0] ADDR_INDIRECT = 5'h00;
    localparam logic [4:0] ADDR_TIMER = 5'h01;
    localparam logic [4:0] ADDR_PCL = 5'h02;
    localparam logic [4:0] ADDR_STATUS = 5'h03;
    localparam logic [4:0] ADDR_FSR = 5'h04;
    localparam logic [4:0] ADDR_PORT_A = 5'h05;
    localparam logic [4:0] ADDR_PORT_B = 5'h06;
    localparam logic [4:0] ADDR_PORT_C = 5'h07;
    localparam logic [4:0] ADDR_RAM_FIRST = 5'h08;
    // mode selector codes
    localparam logic [3:0] MODE_CMP = 4'h8;
    localparam logic [3:0] MODE_WAKE_PEND = 4'h9;
    localparam logic [3:0] MODE_WAKE_EDGE = 4'hA;
    localparam logic [3:0] MODE_WAKE_EN = 4'hB;
    localparam logic [3:0] MODE_SCHMITT = 4'hC;
    localparam logic [3:0] MODE_LEVEL = 4'hD;
    localparam logic [3:0] MODE_PULLUP = 4'hE;
    localparam logic [3:0] MODE_DIR = 4'hF;
    localparam logic [3:0] MODE_RESET = 4'hF;
    // reset and fixed values
    localparam logic [7:0] CFG_RESET = 8'hFF;
    localparam logic [7:0] OPTION_RESET = 8'hFF;
    localparam logic [7:0] STATUS_RESET = 8'h18;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam logic [10:0] PC_ZERO = 11'h000;
    localparam logic [3:0] DIV_NONE = 4'h0;
    localparam logic [3:0] TIMER_DIV_BIAS = 4'h1;
    localparam logic [1:0] OPT_FORCED = 2'h3;

    typedef enum logic [1:0] {PORT_A, PORT_B, PORT_C} port_sel_e;
    typedef enum logic [2:0] {ALU_NONE, ALU_ADD, ALU_SUB, ALU_RR, ALU_RL} alu_op_e;

    typedef struct packed {
        logic [2:0] program_page_select;
        logic watchdog_expired_flag;
        logic powerdown_flag;
        logic zero;
        logic nibble_carry;
        logic carry;
    } alu_status_s;

    typedef struct packed {
        logic timer_address_select;
        logic timer_irq_enable_n;
        logic timer_source_ext;
        logic timer_edge_select;
        logic prescaler_assign;
        logic [2:0] prescaler_ratio;
    } timer_option_s;

    typedef struct packed {
        logic enable_n;
        logic drive_out_n;
        logic [4:0] spare;
        logic result;
    } comparator_s;

    typedef struct packed {
        logic [7:0] dir_a, dir_b, dir_c;
        logic [7:0] pull_a, pull_b, pull_c;
        logic [7:0] level_a, level_b, level_c;
        logic [7:0] schmitt_b, schmitt_c;
        logic [7:0] wake_en_b, wake_edge_b;
    } port_cfg_s;

    localparam port_cfg_s PORT_CFG_RESET = '{default: 8'hFF};
endpackage

// ---- mcu_special_function_regs.sv ----
// special-function registers, port control, alu flags and call stack
// Behaviour
// - port B control write at mode 09h swaps operand with wake flags, clearing them
// - wake flag sets on a valid enabled edge of its port B pin
// - port B control write at mode 08h swaps operand with comparator register
// - comparator result bit is 1 when plus input exceeds minus input
// - reset loads all port control registers with FFh
// - reset loads mode selector with 0Fh
// - file address 00h reaches the register picked by pointer low five bits
// - eight-deep, eleven-bit push/pop return stack
// - fixed decode of file addresses 01h through 07h
// - without port C, address 07h reads back the port C output latch instead of the pins
// - status writable except time-out and power-down flags
// - alu flag update overrides a status write in the same instruction
// - status bits 6:5 choose the 512-word program page; bit 7 shifts out of the 11-bit page base
// - time-out and power-down flags follow power-up, clear, sleep, expiry
// - zero, nibble carry, carry reflect add and inverted subtract borrow
// - rotates load carry from shifted bit; carry feeds add/sub when enabled
// - extended fuse set forces option bits 7 and 6 to 1
// - option bit 7 maps address 01h to operand register or timer
// - option bit 6 low enables the timer rollover interrupt
// - timer source and edge selects come from the option register
// - prescaler assign routes divider to timer or watchdog
// - reset sets every option bit
// - mode selector holds and steers port control writes
module mcu_special_function_regs
    import sfr_pkg::*;
#(
    parameter bit HAS_PORT_C = 1'b1
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic srst_i,
    // file register access
    input wire logic [4:0] file_addr_i,
    input wire logic file_wr_i,
    input wire logic [7:0] file_wdata_i,
    output logic [7:0] file_rdata_o,
    // operand, mode, option writes
    input wire logic w_wr_i,
    input wire logic [7:0] w_wdata_i,
    input wire logic mode_wr_i,
    input wire logic [3:0] mode_wdata_i,
    input wire logic option_wr_i,
    input wire logic [7:0] option_wdata_i,
    input wire logic pctl_wr_i,
    input wire port_sel_e pctl_port_i,
    // alu
    input wire alu_op_e alu_op_i,
    input wire logic [7:0] alu_a_i,
    input wire logic [7:0] alu_b_i,
    output logic [7:0] alu_result_o,
    // stack
    input wire logic push_i,
    input wire logic pop_i,
    input wire logic [10:0] push_data_i,
    output logic [10:0] stack_top_o,
    // fuses and events
    input wire logic extended_option_fuse_i,
    input wire logic carry_input_enable_n_i,
    input wire logic watchdog_clear_instr_i,
    input wire logic sleep_instr_i,
    input wire logic watchdog_expiry_i,
    input wire logic timer_tick_i,
    // pins
    input wire logic [23:0] port_pins_i,
    input wire logic cmp_plus_gt_minus_i,
    output logic cmp_out_o,
    output logic cmp_out_oe_n_o,
    // register state
    output logic [7:0] w_o,
    output logic [3:0] mode_o,
    output timer_option_s option_o,
    output alu_status_s status_o,
    output port_cfg_s port_cfg_o,
    output logic [7:0] wake_pending_o,
    output logic [7:0] timer_count_o,
    output logic [7:0] pc_low_o,
    output logic [7:0] port_a_o,
    output logic [7:0] port_b_o,
    output logic [7:0] port_c_o,
    // derived controls
    output logic [10:0] page_base_o,
    output logic [3:0] timer_div_log2_o,
    output logic [3:0] wdt_div_log2_o,
    output logic timer_irq_enable_o
);
    // file address after indirection
    function automatic logic [4:0] eff_addr(input logic [4:0] a, input logic [7:0] f);
        return (a == ADDR_INDIRECT) ? f[FILE_AW-1:0] : a;
    endfunction

    function automatic logic [4:0] ram_index(input logic [4:0] a);
        return a - ADDR_RAM_FIRST;
    endfunction

    logic [23:0] pins_meta, pins_sync;
    logic [7:0] wake_prev, wake_valid;
    logic gt_meta, gt_sync;
    logic [7:0] w, next_w, indirect_pointer, next_fsr, pcl, next_pcl, timer, next_timer;
    logic [7:0] wake, next_wake, pa, next_pa, pb, next_pb, pc, next_pc;
    logic [3:0] mode, next_mode;
    port_cfg_s cfg, next_cfg;
    comparator_s cmp, next_cmp;
    alu_status_s status, next_status;
    timer_option_s option, next_option;
    logic [7:0] ram [RAM_DEPTH];
    logic [7:0] next_ram [RAM_DEPTH];
    logic [10:0] stack [STACK_DEPTH];
    logic [10:0] next_stack [STACK_DEPTH];
    logic [4:0] wr_addr, rd_addr;
    logic [7:0] alu_res, alu_opb, next_rdata;
    logic [8:0] alu_sum;
    logic [4:0] alu_nib;
    logic alu_cin, alu_rot_c, alu_sub;
    logic is_swap_b;

    // two-stage pin synchronisers and edge history
    always_ff @(posedge sys_clk_i)
    begin
        pins_meta <= port_pins_i;
        pins_sync <= pins_meta;
        gt_meta <= cmp_plus_gt_minus_i;
        gt_sync <= gt_meta;
        wake_prev <= pins_sync[15:8];
    end

    // enabled edges of the wake pins
    always_comb
    begin
        for (int i = 0; i < DATA_W; i++)
        begin
            wake_valid[i] = cfg.wake_edge_b[i] ? (wake_prev[i] & ~pins_sync[8+i])
                                               : (~wake_prev[i] & pins_sync[8+i]);
        end
        wake_valid = wake_valid & ~cfg.wake_en_b;
    end

    // alu with carry-through and inverted borrow
    always_comb
    begin
        alu_sub = (alu_op_i == ALU_SUB);
        alu_opb = alu_sub ? ~alu_b_i : alu_b_i;
        alu_cin = carry_input_enable_n_i ? alu_sub : status.carry;
        alu_sum = {1'b0, alu_a_i} + {1'b0, alu_opb} + {8'h00, alu_cin};
        alu_nib = {1'b0, alu_a_i[3:0]} + {1'b0, alu_opb[3:0]} + {4'h0, alu_cin};
        alu_rot_c = 1'b0;
        unique case (alu_op_i)
            ALU_ADD, ALU_SUB: alu_res = alu_sum[7:0];
            ALU_RR:
            begin
                alu_res = {status.carry, alu_a_i[7:1]};
                alu_rot_c = alu_a_i[0];
            end
            ALU_RL:
            begin
                alu_res = {alu_a_i[6:0], status.carry};
                alu_rot_c = alu_a_i[7];
            end
            default: alu_res = alu_a_i; // no-op and unused codes pass operand a
        endcase
    end

    assign wr_addr = eff_addr(file_addr_i, indirect_pointer);
    assign is_swap_b = pctl_wr_i && (pctl_port_i == PORT_B);

    // next values of the register file
    always_comb
    begin
        next_w = w;
        next_fsr = indirect_pointer;
        next_pcl = pcl;
        next_timer = timer_tick_i ? timer + 8'h01 : timer;
        next_pa = pa;
        next_pb = pb;
        next_pc = pc;
        next_ram = ram;
        next_mode = mode;
        next_cfg = cfg;
        next_cmp = cmp;
        next_cmp.result = gt_sync;
        next_status = status;
        next_option = option;
        next_wake = wake | wake_valid;
        if (file_wr_i)
        begin
            unique case (wr_addr)
                ADDR_INDIRECT: ; // no physical register behind 00h
                ADDR_TIMER:
                begin
                    if (option.timer_address_select)
                        next_timer = file_wdata_i;
                    else
                        next_w = file_wdata_i;
                end
                ADDR_PCL: next_pcl = file_wdata_i;
                ADDR_STATUS:
                begin
                    next_status = alu_status_s'(file_wdata_i);
                    next_status.watchdog_expired_flag = status.watchdog_expired_flag;
                    next_status.powerdown_flag = status.powerdown_flag;
                end
                ADDR_FSR: next_fsr = file_wdata_i;
                ADDR_PORT_A: next_pa = file_wdata_i;
                ADDR_PORT_B: next_pb = file_wdata_i;
                ADDR_PORT_C: next_pc = file_wdata_i;
                default: next_ram[ram_index(wr_addr)] = file_wdata_i;
            endcase
        end
        if (w_wr_i)
            next_w = w_wdata_i;
        if (mode_wr_i)
            next_mode = mode_wdata_i;
        if (option_wr_i)
            next_option = timer_option_s'(option_wdata_i);
        if (extended_option_fuse_i)
            {next_option.timer_address_select, next_option.timer_irq_enable_n} = OPT_FORCED;
        // port control write steered by the mode selector
        if (pctl_wr_i)
        begin
            unique case (mode)
                MODE_CMP:
                begin
                    if (is_swap_b)
                    begin
                        next_w = cmp;
                        next_cmp.enable_n = w[7];
                        next_cmp.drive_out_n = w[6];
                        next_cmp.spare = w[5:1];
                    end
                end
                MODE_WAKE_PEND:
                begin
                    if (is_swap_b)
                    begin
                        next_w = wake;
                        next_wake = wake_valid;
                    end
                end
                MODE_WAKE_EDGE: if (is_swap_b) next_cfg.wake_edge_b = w;
                MODE_WAKE_EN: if (is_swap_b) next_cfg.wake_en_b = w;
                MODE_SCHMITT:
                begin
                    if (pctl_port_i == PORT_B) next_cfg.schmitt_b = w;
                    if (pctl_port_i == PORT_C) next_cfg.schmitt_c = w;
                end
                MODE_LEVEL:
                begin
                    if (pctl_port_i == PORT_A) next_cfg.level_a = w;
                    if (pctl_port_i == PORT_B) next_cfg.level_b = w;
                    if (pctl_port_i == PORT_C) next_cfg.level_c = w;
                end
                MODE_PULLUP:
                begin
                    if (pctl_port_i == PORT_A) next_cfg.pull_a = w;
                    if (pctl_port_i == PORT_B) next_cfg.pull_b = w;
                    if (pctl_port_i == PORT_C) next_cfg.pull_c = w;
                end
                MODE_DIR:
                begin
                    if (pctl_port_i == PORT_A) next_cfg.dir_a = w;
                    if (pctl_port_i == PORT_B) next_cfg.dir_b = w;
                    if (pctl_port_i == PORT_C) next_cfg.dir_c = w;
                end
                default: ; // reserved mode codes do nothing
            endcase
        end
        // watchdog and power-down flags, expiry last so it wins
        if (watchdog_clear_instr_i)
        begin
            next_status.watchdog_expired_flag = 1'b1;
            next_status.powerdown_flag = 1'b1;
        end
        if (sleep_instr_i)
        begin
            next_status.watchdog_expired_flag = 1'b1;
            next_status.powerdown_flag = 1'b0;
        end
        if (watchdog_expiry_i)
            next_status.watchdog_expired_flag = 1'b0;
        // alu flags land after any status write
        unique case (alu_op_i)
            ALU_ADD, ALU_SUB:
            begin
                next_status.zero = (alu_sum[7:0] == ZERO_BYTE);
                next_status.nibble_carry = alu_nib[4];
                next_status.carry = alu_sum[8];
            end
            ALU_RR, ALU_RL: next_status.carry = alu_rot_c;
            ALU_NONE: ;
        endcase
    end

    // register file storage
    always_ff @(posedge sys_clk_i)
    begin
        if (srst_i)
        begin
            w <= ZERO_BYTE;
            indirect_pointer <= ZERO_BYTE;
            pcl <= ZERO_BYTE;
            timer <= ZERO_BYTE;
            pa <= ZERO_BYTE;
            pb <= ZERO_BYTE;
            pc <= ZERO_BYTE;
            for (int i = 0; i < RAM_DEPTH; i++)
                ram[i] <= ZERO_BYTE;
            mode <= MODE_RESET;
            cfg <= PORT_CFG_RESET;
            cmp <= CFG_RESET;
            wake <= CFG_RESET;
            status <= STATUS_RESET;
            option <= OPTION_RESET;
        end
        else
        begin
            w <= next_w;
            indirect_pointer <= next_fsr;
            pcl <= next_pcl;
            timer <= next_timer;
            pa <= next_pa;
            pb <= next_pb;
            pc <= next_pc;
            ram <= next_ram;
            mode <= next_mode;
            cfg <= next_cfg;
            cmp <= next_cmp;
            wake <= next_wake;
            status <= next_status;
            option <= next_option;
        end
    end

    // shift-register return stack, top at entry 0
    always_comb
    begin
        next_stack = stack;
        if (push_i)
        begin
            next_stack[0] = push_data_i;
            for (int i = 1; i < STACK_DEPTH; i++)
                next_stack[i] = pop_i ? stack[i] : stack[i-1];
        end
        else if (pop_i)
        begin
            for (int i = 0; i < STACK_DEPTH - 1; i++)
                next_stack[i] = stack[i+1];
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (srst_i)
        begin
            for (int i = 0; i < STACK_DEPTH; i++)
                stack[i] <= PC_ZERO;
        end
        else
            stack <= next_stack;
    end

    // read mux; ports A and B read the pins, port C reads them only when present
    assign rd_addr = eff_addr(file_addr_i, indirect_pointer);
    always_comb
    begin
        unique case (rd_addr)
            ADDR_INDIRECT: next_rdata = ZERO_BYTE;
            ADDR_TIMER: next_rdata = option.timer_address_select ? timer : w;
            ADDR_PCL: next_rdata = pcl;
            ADDR_STATUS: next_rdata = status;
            ADDR_FSR: next_rdata = indirect_pointer;
            ADDR_PORT_A: next_rdata = pins_sync[7:0];
            ADDR_PORT_B: next_rdata = pins_sync[15:8];
            ADDR_PORT_C: next_rdata = HAS_PORT_C ? pins_sync[23:16] : pc;
            default: next_rdata = ram[ram_index(rd_addr)];
        endcase
    end

    // registered outputs
    always_ff @(posedge sys_clk_i)
    begin
        if (srst_i)
        begin
            file_rdata_o <= ZERO_BYTE;
            alu_result_o <= ZERO_BYTE;
            page_base_o <= PC_ZERO;
            timer_div_log2_o <= DIV_NONE;
            wdt_div_log2_o <= DIV_NONE;
            timer_irq_enable_o <= 1'b0;
            cmp_out_o <= 1'b0;
            cmp_out_oe_n_o <= 1'b1;
        end
        else
        begin
            file_rdata_o <= next_rdata;
            alu_result_o <= alu_res;
            page_base_o <= PC_W'(status.program_page_select) << PAGE_SHIFT;
            timer_div_log2_o <= option.prescaler_assign ? DIV_NONE
                : 4'(option.prescaler_ratio) + TIMER_DIV_BIAS;
            wdt_div_log2_o <= option.prescaler_assign ? 4'(option.prescaler_ratio)
                : DIV_NONE;
            timer_irq_enable_o <= ~option.timer_irq_enable_n;
            cmp_out_o <= gt_sync & ~cmp.enable_n;
            cmp_out_oe_n_o <= cmp.enable_n | cmp.drive_out_n;
        end
    end

    assign w_o = w;
    assign mode_o = mode;
    assign option_o = option;
    assign status_o = status;
    assign port_cfg_o = cfg;
    assign wake_pending_o = wake;
    assign timer_count_o = timer;
    assign pc_low_o = pcl;
    assign port_a_o = pa;
    assign port_b_o = pb;
    assign port_c_o = pc;
    assign stack_top_o = stack[0];

    // checks
    property p_wake_swap;
        @(posedge sys_clk_i) disable iff (srst_i)
        is_swap_b && mode == MODE_WAKE_PEND && !w_wr_i
        |=> w == $past(wake) && (wake & ~$past(wake_valid)) == ZERO_BYTE;
    endproperty
    a_wake_swap: assert property (p_wake_swap) else $error("wake swap bad");

    property p_wake_set;
        @(posedge sys_clk_i) disable iff (srst_i)
        wake_valid != ZERO_BYTE |=> (wake & $past(wake_valid)) == $past(wake_valid);
    endproperty
    a_wake_set: assert property (p_wake_set) else $error("wake edge lost");

    property p_cmp_swap;
        @(posedge sys_clk_i) disable iff (srst_i)
        is_swap_b && mode == MODE_CMP && !w_wr_i
        |=> w == $past(cmp) && cmp.enable_n == $past(w[7]) && cmp.drive_out_n == $past(w[6]);
    endproperty
    a_cmp_swap: assert property (p_cmp_swap) else $error("cmp swap bad");

    property p_cmp_result;
        @(posedge sys_clk_i) disable iff (srst_i)
        cmp_plus_gt_minus_i [*4] |-> cmp.result;
    endproperty
    a_cmp_result: assert property (p_cmp_result) else $error("cmp result stale");

    property p_reset_vals;
        @(posedge sys_clk_i) disable iff (srst_i)
        $fell(srst_i) |-> cfg == PORT_CFG_RESET && mode == MODE_RESET && option == OPTION_RESET;
    endproperty
    a_reset_vals: assert property (p_reset_vals) else $error("reset value bad");

    property p_indirect;
        @(posedge sys_clk_i) disable iff (srst_i)
        file_wr_i && file_addr_i == ADDR_INDIRECT && indirect_pointer[4:0] >= ADDR_RAM_FIRST
        |=> ram[ram_index($past(indirect_pointer[4:0]))] == $past(file_wdata_i);
    endproperty
    a_indirect: assert property (p_indirect) else $error("indirect write lost");

    property p_stack_pop;
        @(posedge sys_clk_i) disable iff (srst_i)
        push_i && !pop_i ##1 pop_i && !push_i |=> stack_top_o == $past(stack[1]);
    endproperty
    a_stack_pop: assert property (p_stack_pop) else $error("stack pop bad");

    property p_status_ro;
        @(posedge sys_clk_i) disable iff (srst_i)
        file_wr_i && wr_addr == ADDR_STATUS && !sleep_instr_i && !watchdog_clear_instr_i
            && !watchdog_expiry_i
        |=> $stable(status.watchdog_expired_flag) && $stable(status.powerdown_flag);
    endproperty
    a_status_ro: assert property (p_status_ro) else $error("status flag written");

    property p_flags_win;
        @(posedge sys_clk_i) disable iff (srst_i)
        file_wr_i && wr_addr == ADDR_STATUS && alu_op_i == ALU_ADD
        |=> status.zero == ($past(alu_res) == ZERO_BYTE);
    endproperty
    a_flags_win: assert property (p_flags_win) else $error("flags lost");

    property p_sleep;
        @(posedge sys_clk_i) disable iff (srst_i)
        sleep_instr_i && !watchdog_expiry_i |=> status.watchdog_expired_flag
            && !status.powerdown_flag;
    endproperty
    a_sleep: assert property (p_sleep) else $error("sleep flags bad");

    property p_fuse;
        @(posedge sys_clk_i) disable iff (srst_i)
        extended_option_fuse_i |=> option.timer_address_select && option.timer_irq_enable_n;
    endproperty
    a_fuse: assert property (p_fuse) else $error("fuse bits not forced");

    property p_timer_read;
        @(posedge sys_clk_i) disable iff (srst_i)
        file_addr_i == ADDR_TIMER && !option.timer_address_select |=> file_rdata_o == $past(w);
    endproperty
    a_timer_read: assert property (p_timer_read) else $error("01h not operand");
endmodule // mcu_special_function_regs

// ---- mcu_special_function_regs_bench.sv ----
// self-checking bench for the special-function register bank
module mcu_special_function_regs_bench
    import sfr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst, fw, ww, mw, ow, pw, push, pop, fuse, cin_n, cmp, irq;
    logic co, coe, wclr, slp, wexp, tick;
    logic [4:0] fa;
    logic [7:0] fd, wd, od, aa, ab, rd, res, w, wk, v, m, tc;
    logic [3:0] md, mo, tdiv, wdiv;
    logic [10:0] pd, top, pb, e;
    logic [10:0] d [9];
    logic [23:0] pins;
    logic [31:0] seed = 32'hEE4E4125;
    logic c;
    port_sel_e pp;
    alu_op_e op;
    timer_option_s opt;
    alu_status_s st;
    port_cfg_s cfg;
    int err_total = 0;
    int cmp_count = 0;
    // device under test, event pulses idle until the sleep/expiry/clear step
    mcu_special_function_regs dut_u (.sys_clk_i(clk), .srst_i(rst), .file_addr_i(fa),
        .file_wr_i(fw), .file_wdata_i(fd), .file_rdata_o(rd), .w_wr_i(ww), .w_wdata_i(wd),
        .mode_wr_i(mw), .mode_wdata_i(md), .option_wr_i(ow), .option_wdata_i(od),
        .pctl_wr_i(pw), .pctl_port_i(pp), .alu_op_i(op), .alu_a_i(aa), .alu_b_i(ab),
        .alu_result_o(res), .push_i(push), .pop_i(pop), .push_data_i(pd), .stack_top_o(top),
        .extended_option_fuse_i(fuse), .carry_input_enable_n_i(cin_n),
        .watchdog_clear_instr_i(wclr), .sleep_instr_i(slp), .watchdog_expiry_i(wexp),
        .timer_tick_i(tick), .port_pins_i(pins), .cmp_plus_gt_minus_i(cmp), .cmp_out_o(co),
        .cmp_out_oe_n_o(coe), .w_o(w), .mode_o(mo), .option_o(opt), .status_o(st),
        .port_cfg_o(cfg), .wake_pending_o(wk), .timer_count_o(tc), .pc_low_o(), .port_a_o(),
        .port_b_o(), .port_c_o(), .page_base_o(pb), .timer_div_log2_o(tdiv),
        .wdt_div_log2_o(wdiv), .timer_irq_enable_o(irq));
    // 50 ns clock
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    function automatic logic [7:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed[7:0];
    endfunction
    // expected {zero, nibble carry, carry, result}
    function automatic logic [10:0] alu_exp(alu_op_e o, logic [7:0] a, b, logic ci);
        logic [8:0] s;
        logic [4:0] n;
        if (o == ALU_RR) return {2'b00, a[0], ci, a[7:1]};
        if (o == ALU_RL) return {2'b00, a[7], a[6:0], ci};
        s = (o == ALU_ADD) ? a + b + ci : {1'b1, a} - b - {8'h00, ~ci};
        n = (o == ALU_ADD) ? a[3:0] + b[3:0] + ci : {1'b1, a[3:0]} - b[3:0] - {4'h0, ~ci};
        return {s[7:0] == 8'h00, n[4], s[8], s[7:0]};
    endfunction
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        cmp_count++;
        if (g !== x)
        begin
            err_total++;
            $display("[ERR] %0t got %h expected %h", $time, g, x);
        end
    endtask
    task automatic final_report();
        if (err_total == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // port-control write through the operand register
    task automatic pctl(input logic [3:0] mode, input logic [7:0] val, input port_sel_e p);
        @(negedge clk) {ww, wd, mw, md} = {1'b1, val, 1'b1, mode};
        @(negedge clk) {ww, mw, pw} = 3'b001;
        pp = p;
        @(negedge clk) pw = 1'b0;
    endtask
    task automatic fwr(input logic [4:0] a, input logic [7:0] val);
        @(negedge clk) {fa, fd, fw} = {a, val, 1'b1};
        @(negedge clk) fw = 1'b0;
    endtask
    task automatic frd(input logic [4:0] a, input logic [7:0] x);
        @(negedge clk) fa = a;
        @(negedge clk) chk(rd, x);
    endtask
    initial
    begin
        #2ms;
        err_total++;
        final_report();
    end
    initial
    begin
        {rst, fw, ww, mw, ow, pw, push, pop, fuse, cin_n, cmp} = 11'h400;
        {wclr, slp, wexp, tick} = 4'h0;
        {fa, fd, wd, od, aa, ab, md, pd, pins} = '0;
        pp = PORT_B;
        op = ALU_NONE;
        repeat (8) @(negedge clk);
        rst = 1'b0;
        chk(mo, MODE_RESET);
        chk(&cfg, 1'b1);
        chk(opt, 8'hFF);
        chk(st, 8'h18);
        pctl(MODE_WAKE_EDGE, 8'h00, PORT_B);
        pctl(MODE_WAKE_EN, 8'h00, PORT_B);
        chk({cfg.wake_en_b, cfg.wake_edge_b, mo}, {16'h0000, MODE_WAKE_EN});
        pctl(MODE_WAKE_PEND, rnd(), PORT_B);
        chk({w, wk}, 16'hFF00);
        m = rnd();
        pins[15:8] = m;
        repeat (4) @(negedge clk);
        chk(wk, m);
        pctl(MODE_WAKE_PEND, rnd(), PORT_B);
        chk({w, wk}, {m, 8'h00});
        v = rnd();
        pctl(MODE_CMP, v, PORT_B);
        chk(w, 8'hFE);
        cmp = 1'b1;
        repeat (4) @(negedge clk);
        pctl(MODE_CMP, 8'h00, PORT_B);
        chk(w, {v[7:1], 1'b1});
        @(negedge clk) chk({co, coe}, 2'b10);
        for (int k = 0; k < 4; k++)
        begin
            m = 8'h08 + (rnd() % 8'd24);
            v = rnd();
            fwr(ADDR_FSR, m);
            fwr(ADDR_INDIRECT, v);
            frd(m[4:0], v);
            frd(ADDR_INDIRECT, v);
        end
        fwr(ADDR_STATUS, 8'h67);
        chk(st, 8'h7F);
        @(negedge clk) chk(pb, 11'h600);
        c = 1'b1;
        // first op lands together with a status write
        for (int k = 0; k < 16; k++)
        begin
            @(negedge clk) {aa, ab} = {rnd(), (k == 0) ? 8'h01 : rnd()};
            if (k == 0) {aa, fa, fd, fw} = {8'hFF, ADDR_STATUS, 8'h67, 1'b1};
            op = alu_op_e'((k < 4) ? k % 4 + 1 : rnd() % 4 + 1);
            e = alu_exp(op, aa, ab, c);
            @(negedge clk) chk((op > ALU_SUB) ? {st.carry, res} : {st[2:0], res},
                (op > ALU_SUB) ? e[8:0] : e);
            c = e[8];
            op = ALU_NONE;
            fw = 1'b0;
        end
        v = rnd() & 8'h7F;
        @(negedge clk) {ow, od} = {1'b1, v};
        @(negedge clk) ow = 1'b0;
        @(negedge clk) chk(opt, v);
        chk(tdiv, v[3] ? 4'h0 : {1'b0, v[2:0]} + 4'h1);
        chk({wdiv, irq}, {v[3] ? {1'b0, v[2:0]} : 4'h0, ~v[6]});
        m = rnd();
        fwr(ADDR_TIMER, m);
        chk(w, m);
        // sleep, expiry and clear pulses, one tick
        @(negedge clk) {slp, tick} = 2'b11;
        @(negedge clk) {slp, tick, wexp} = 3'b001;
        chk({st[4:3], tc}, {2'b10, 8'h01});
        @(negedge clk) {wexp, wclr} = 2'b01;
        chk(st[4:3], 2'b00);
        @(negedge clk) wclr = 1'b0;
        chk(st[4:3], 2'b11);
        fuse = 1'b1;
        repeat (2) @(negedge clk);
        chk(opt[7:6], 2'b11);
        for (int i = 0; i < 9; i++)
        begin
            d[i] = 11'({rnd(), rnd()});
            @(negedge clk) {push, pd} = {1'b1, d[i]};
            @(negedge clk) {push, pop} = {1'b0, i == 8}; // last push runs into a pop
            chk(top, d[i]);
        end
        for (int i = 0; i < 8; i++)
        begin
            if (i > 0)
                @(negedge clk) pop = 1'b1;
            @(negedge clk) pop = 1'b0;
            chk(top, d[(i < 7) ? 7 - i : 1]);
        end
        final_report();
    end
endmodule // mcu_special_function_regs_bench
